/* inc/flash_prot_pkg.sv */
// shared constants and types for the flash programming and protection controller
package flash_prot_pkg;
	// register offsets on the plain register port
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] REG_ADDR_LO = 8'h02;
	localparam logic [7:0] REG_ADDR_HI = 8'h03;
	localparam logic [7:0] REG_DATA = 8'h04;
	// control register bit positions
	localparam int CTRL_START = 0;
	localparam int CTRL_ERASE = 1;
	localparam int CTRL_OPT = 2;
	localparam int CTRL_PIN_OE = 3;
	localparam int CTRL_PIN_OUT = 4;
	localparam int CTRL_ERR_CLR = 7;
	// status register bit positions
	localparam int STAT_BUSY = 0;
	localparam int STAT_EXTERNAL = 1;
	localparam int STAT_COMM = 2;
	localparam int STAT_ENTRY35 = 3;
	localparam int STAT_ENTRY38 = 4;
	localparam int STAT_READOUT = 5;
	localparam int STAT_WRITE = 6;
	localparam int STAT_ERR = 7;
	// option byte layout
	localparam int OPT_READOUT = 0;
	localparam int OPT_WRITE = 1;
	localparam int OPT_SEC0_LSB = 2;
	localparam int OPT_SEC0_W = 2;
	localparam int OPT_CLKSEL = 4;
	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	// entry sequence pulse counts
	localparam int PULSE_CNT_W = 6;
	localparam logic [PULSE_CNT_W-1:0] ENTRY_PULSES_EXT = 6'h23;
	localparam logic [PULSE_CNT_W-1:0] ENTRY_PULSES_RC = 6'h26;
	// sector 0 is (1 << SEC0_UNIT_LOG2) bytes times 2**field
	localparam int SEC0_UNIT_LOG2 = 9;
	localparam int ROW_LOG2 = 5;
	localparam int SYNC_W = 3;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_MASS = 3'b001,
		S_ERASE = 3'b010,
		S_PROG = 3'b011,
		S_WAIT = 3'b100,
		S_DONE = 3'b101
	} fsm_e;
endpackage : flash_prot_pkg

/* src/incircuit_entry_detect.sv */
// entry sequence counter running on the in-circuit clock pin
`timescale 1ns/1ps
module incircuit_entry_detect (
	input wire logic i_incircuit_clock_pin,
	input wire logic i_hold_n,
	input wire logic i_incircuit_data_pin,
	output logic o_entry_ext_clock,
	output logic o_entry_rc_clock
);
	import flash_prot_pkg::*;

	logic [PULSE_CNT_W-1:0] pulse_count;
	logic [PULSE_CNT_W-1:0] next_pulse_count;

	// counts clock pulses with data high while reset is held low
	always_comb begin
		next_pulse_count = pulse_count;
		if (i_hold_n || !i_incircuit_data_pin) begin
			next_pulse_count = '0;
		end else if (pulse_count != '1) begin
			next_pulse_count = pulse_count + 1'b1;
		end
	end

	always_ff @(posedge i_incircuit_clock_pin) begin
		pulse_count <= next_pulse_count;
	end

	// flags are levels that hold once the tool stops clocking
	always_ff @(posedge i_incircuit_clock_pin) begin
		o_entry_ext_clock <= (next_pulse_count == ENTRY_PULSES_EXT);
		o_entry_rc_clock <= (next_pulse_count == ENTRY_PULSES_RC);
	end
endmodule : incircuit_entry_detect

/* src/flash_program_mode_protection.sv */
// program flash controller: programming modes, sector scope and option protections
// What this block does
// - flash is programmed one byte or a latched row of up to 32 bytes
// - erasing one sector leaves every other sector untouched
// - external tool may program or erase sectors 0, 1 and option row
// - in-application programming may not touch sector 0
// - pulse sequence on clock/data pins while reset held enters comm mode
// - comm mode selects the system memory reset vector
// - in comm mode the tool downloads driver code and runs it from RAM
// - 35 pulses use external clock input, 38 pulses force internal RC
// - any reset returns the clock pin to input with pull-up
// - readout protection blocks extraction and flash writes
// - removing readout protection first erases all program memory
// - readout protection comes from a readout-protect option bit
// - write protection rejects program and erase of program memory
// - write protection can never be cleared once set
// - write protection comes from a write-protect option bit
// - the two protections are selected independently
// - sector 0 size comes from an option byte field
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module flash_program_mode_protection #(
	parameter int FLASH_AW = 13,
	parameter int ROW_BYTES = 32
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_incircuit_clock_pin,
	input wire logic i_incircuit_data_pin,
	input wire logic i_tool_socket_mode,
	input wire logic [7:0] i_option_byte,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic [FLASH_AW-1:0] o_flash_addr,
	output logic [7:0] o_flash_wdata,
	output logic o_flash_prog,
	output logic o_flash_erase,
	output logic o_flash_opt_sel,
	output logic o_flash_sector,
	input wire logic i_flash_busy,
	output logic o_fetch_system_vector,
	output logic o_ext_clock_select,
	output logic o_force_internal_rc,
	output logic o_readout_block,
	output logic o_incircuit_clock_pin_out,
	output logic o_incircuit_clock_pin_oe
);
	import flash_prot_pkg::*;

	localparam logic [FLASH_AW:0] SEC0_ONE = (FLASH_AW+1)'(1);
	localparam logic [ROW_LOG2-1:0] LAST_IDX = ROW_LOG2'(ROW_BYTES - 1);

	logic entry_ext_link;
	logic entry_rc_link;
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic [SYNC_W-1:0] sync3;
	logic [SYNC_W-1:0] pin_stable;

	logic loaded;
	logic comm_mode;
	logic socket_mode;
	logic entry35;
	logic entry38;
	logic opt_readout;
	logic opt_write;
	logic [OPT_SEC0_W-1:0] opt_sec0;
	logic opt_clksel;

	fsm_e state;
	fsm_e resume;
	logic settle;
	logic [ROW_LOG2-1:0] idx;
	logic mass_sec;
	logic op_opt;
	logic op_erase;
	logic err;
	logic pin_oe;
	logic pin_out;
	logic [15:0] addr;
	logic [7:0] row_latch [0:ROW_BYTES-1];
	logic [ROW_BYTES-1:0] row_valid;

	logic external;
	logic wr_ctrl;
	logic req_any;
	logic req_opt;
	logic req_erase;
	logic [FLASH_AW:0] sec0_limit;
	logic addr_sector;
	logic rp_removal;
	logic reject;
	logic accept;

	incircuit_entry_detect u_entry (
		.i_incircuit_clock_pin(i_incircuit_clock_pin),
		.i_hold_n(i_rst_n),
		.i_incircuit_data_pin(i_incircuit_data_pin),
		.o_entry_ext_clock(entry_ext_link),
		.o_entry_rc_clock(entry_rc_link)
	);

	// pin-level inputs cross on three flops; no reset so they run through reset
	always_ff @(posedge i_mclk) begin
		sync1 <= {i_tool_socket_mode, entry_rc_link, entry_ext_link};
		sync2 <= sync1;
		sync3 <= sync2;
	end

	generate
		for (genvar b = 0; b < SYNC_W; b++) begin : g_agree
			always_ff @(posedge i_mclk) begin
				if (sync2[b] == sync3[b]) begin
					pin_stable[b] <= sync3[b];
				end
			end
		end
	endgenerate

	// straps and options caught once, first cycle after release
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			loaded <= 1'b0;
			comm_mode <= 1'b0;
			socket_mode <= 1'b0;
			entry35 <= 1'b0;
			entry38 <= 1'b0;
			opt_readout <= 1'b0;
			opt_write <= 1'b0;
			opt_sec0 <= '0;
			opt_clksel <= 1'b0;
		end else if (!loaded) begin
			loaded <= 1'b1;
			comm_mode <= pin_stable[0] | pin_stable[1];
			entry35 <= pin_stable[0];
			entry38 <= pin_stable[1];
			socket_mode <= pin_stable[2];
			opt_readout <= i_option_byte[OPT_READOUT];
			opt_write <= i_option_byte[OPT_WRITE];
			opt_sec0 <= i_option_byte[OPT_SEC0_LSB +: OPT_SEC0_W];
			opt_clksel <= i_option_byte[OPT_CLKSEL];
		end
	end

	// mode-derived outputs come straight from the captured straps
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_fetch_system_vector <= 1'b0;
			o_ext_clock_select <= 1'b0;
			o_force_internal_rc <= 1'b0;
			o_readout_block <= 1'b0;
		end else begin
			o_fetch_system_vector <= comm_mode;
			o_ext_clock_select <= comm_mode ? entry35 : opt_clksel;
			o_force_internal_rc <= entry38;
			o_readout_block <= opt_readout & external;
		end
	end

	assign external = comm_mode | socket_mode;
	assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
	assign req_any = wr_ctrl && (i_wdata[CTRL_START] || i_wdata[CTRL_ERASE]);
	assign req_opt = i_wdata[CTRL_OPT];
	assign req_erase = i_wdata[CTRL_ERASE];
	assign sec0_limit = SEC0_ONE << (SEC0_UNIT_LOG2 + int'(opt_sec0));
	assign addr_sector = ({1'b0, addr[FLASH_AW-1:0]} >= sec0_limit);

	// clearing the readout option forces a full erase first
	assign rp_removal = req_opt && opt_readout &&
		(req_erase || (row_valid[0] && !row_latch[0][OPT_READOUT]));

	// each protection gates on its own bit
	always_comb begin
		reject = !loaded || state != S_IDLE;
		// nothing passes, so the option row keeps it set
		reject = reject || opt_write;
		// option row only from a tool
		reject = reject || (req_opt && !external);
		reject = reject || (!req_opt && !addr_sector && !external);
		reject = reject || (opt_readout && !rp_removal);
	end

	assign accept = req_any && !reject;

	// error flag: a new rejection wins over a clear in the same cycle
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			err <= 1'b0;
		end else if (req_any && reject) begin
			err <= 1'b1;
		end else if (wr_ctrl && i_wdata[CTRL_ERR_CLR]) begin
			err <= 1'b0;
		end
	end

	// reset puts the clock pin back to input
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pin_oe <= CTRL_RESET[CTRL_PIN_OE];
			pin_out <= CTRL_RESET[CTRL_PIN_OUT];
		end else if (wr_ctrl) begin
			pin_oe <= i_wdata[CTRL_PIN_OE];
			pin_out <= i_wdata[CTRL_PIN_OUT];
		end
	end

	// the tool owns the pin during a session, so the app drive is dropped
	assign o_incircuit_clock_pin_oe = pin_oe & ~comm_mode;
	assign o_incircuit_clock_pin_out = pin_out;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			addr <= ADDR_RESET;
		end else if (i_wr && state == S_IDLE) begin
			if (i_addr == REG_ADDR_LO) begin
				addr[7:0] <= i_wdata;
			end else if (i_addr == REG_ADDR_HI) begin
				addr[15:8] <= i_wdata;
			end
		end
	end

	// row latch; bytes land by low address bits
	always_ff @(posedge i_mclk) begin
		if (i_wr && i_addr == REG_DATA && state == S_IDLE) begin
			row_latch[addr[ROW_LOG2-1:0]] <= i_wdata;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			row_valid <= '0;
		end else if (state == S_DONE) begin
			row_valid <= '0;
		end else if (i_wr && i_addr == REG_DATA && state == S_IDLE) begin
			row_valid[addr[ROW_LOG2-1:0]] <= 1'b1;
		end
	end

	// sequencer; every flash command is a one-cycle pulse then a busy wait
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state <= S_IDLE;
			resume <= S_IDLE;
			settle <= 1'b0;
			idx <= '0;
			mass_sec <= 1'b0;
			op_opt <= 1'b0;
			op_erase <= 1'b0;
			o_flash_prog <= 1'b0;
			o_flash_erase <= 1'b0;
			o_flash_opt_sel <= 1'b0;
			o_flash_sector <= 1'b0;
			o_flash_addr <= '0;
			o_flash_wdata <= '0;
		end else begin
			o_flash_prog <= 1'b0;
			o_flash_erase <= 1'b0;
			case (state)
				S_IDLE: begin
					if (accept) begin
						op_opt <= req_opt;
						op_erase <= req_erase;
						idx <= '0;
						mass_sec <= 1'b0;
						state <= rp_removal ? S_MASS : (req_erase ? S_ERASE : S_PROG);
					end
				end
				// both program sectors erased before the option
				S_MASS: begin
					o_flash_erase <= 1'b1;
					o_flash_opt_sel <= 1'b0;
					o_flash_sector <= mass_sec;
					o_flash_addr <= mass_sec ? sec0_limit[FLASH_AW-1:0] : '0;
					mass_sec <= 1'b1;
					settle <= 1'b1;
					resume <= !mass_sec ? S_MASS : (op_erase ? S_ERASE : S_PROG);
					state <= S_WAIT;
				end
				S_ERASE: begin
					o_flash_erase <= 1'b1;
					o_flash_opt_sel <= op_opt;
					o_flash_sector <= addr_sector;
					o_flash_addr <= addr[FLASH_AW-1:0];
					settle <= 1'b1;
					resume <= S_DONE;
					state <= S_WAIT;
				end
				// walk the row, programming only latched bytes
				S_PROG: begin
					if (op_opt) begin
						o_flash_prog <= 1'b1;
						o_flash_opt_sel <= 1'b1;
						o_flash_wdata <= row_latch[0];
						settle <= 1'b1;
						resume <= S_DONE;
						state <= S_WAIT;
					end else begin
						o_flash_opt_sel <= 1'b0;
						idx <= idx + 1'b1;
						if (row_valid[idx]) begin
							o_flash_prog <= 1'b1;
							o_flash_sector <= addr_sector;
							o_flash_addr <= {addr[FLASH_AW-1:ROW_LOG2], idx};
							o_flash_wdata <= row_latch[idx];
							settle <= 1'b1;
							resume <= (idx == LAST_IDX) ? S_DONE : S_PROG;
							state <= S_WAIT;
						end else if (idx == LAST_IDX) begin
							state <= S_DONE;
						end
					end
				end
				// first cycle lets the macro raise busy before we look at it
				S_WAIT: begin
					if (settle) begin
						settle <= 1'b0;
					end else if (!i_flash_busy) begin
						state <= resume;
					end
				end
				S_DONE: begin
					o_flash_opt_sel <= 1'b0;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// comm mode and entry variant visible to the RAM driver
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				REG_CTRL: o_rdata <= {3'b000, pin_out, pin_oe, 3'b000};
				REG_STATUS: begin
					o_rdata <= {err, opt_write, opt_readout, entry38, entry35,
						comm_mode, external, (state != S_IDLE) || !loaded};
				end
				REG_ADDR_LO: o_rdata <= addr[7:0];
				REG_ADDR_HI: o_rdata <= addr[15:8];
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule : flash_program_mode_protection

/* bench/flash_prot_asserts.sv */
// port checker for the flash controller
`timescale 1ns/1ps
module flash_prot_asserts
	import flash_prot_pkg::*;
#(parameter int FLASH_AW = 13) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_tool_socket_mode,
	input wire logic [7:0] i_option_byte,
	input wire logic [FLASH_AW-1:0] o_flash_addr,
	input wire logic [7:0] o_flash_wdata,
	input wire logic o_flash_prog,
	input wire logic o_flash_erase,
	input wire logic o_flash_opt_sel,
	input wire logic o_fetch_system_vector,
	input wire logic o_ext_clock_select,
	input wire logic o_force_internal_rc,
	input wire logic o_readout_block,
	input wire logic o_incircuit_clock_pin_oe
);
	logic armed;
	logic [7:0] opt_q;
	wire op = o_flash_prog | o_flash_erase;
	wire ext = o_fetch_system_vector | i_tool_socket_mode;
	wire iap_op = op & ~o_flash_opt_sel & ~ext;
	// first byte above sector 0 for the option size caught at load
	wire [31:0] sec0_lo = 32'd1 << (SEC0_UNIT_LOG2 + int'(opt_q[OPT_SEC0_LSB +: OPT_SEC0_W]));
	// options as the design takes them at its load edge
	always_ff @(posedge i_mclk) begin
		armed <= !i_rst_n;
		if (armed && i_rst_n)
			opt_q <= i_option_byte;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	sequence s_quiet;
		!o_flash_prog && !o_flash_erase;
	endsequence
	sequence s_comm_rc;
		o_fetch_system_vector && !o_ext_clock_select;
	endsequence
	a_pulse_gap: assert property (op |=> s_quiet)
		else $error("flash pulse without settle cycle");
	a_wp_blocks: assert property (op |-> !opt_q[OPT_WRITE])
		else $error("flash operation under write protect");
	a_sec0_guard: assert property (iap_op |-> 32'(o_flash_addr) >= sec0_lo)
		else $error("sector 0 written in application mode");
	a_opt_extern: assert property (op && o_flash_opt_sel |-> ext)
		else $error("option row touched without tool");
	a_rc_forced: assert property (o_force_internal_rc |-> s_comm_rc)
		else $error("internal clock forced outside long entry");
	a_oe_reset: assert property (disable iff (1'b0) !i_rst_n |=> !o_incircuit_clock_pin_oe)
		else $error("clock pin driven after reset");
	a_ro_source: assert property (o_readout_block |-> opt_q[OPT_READOUT])
		else $error("readout block without option bit");
	a_ro_nowrite: assert property (o_flash_prog && opt_q[OPT_READOUT] |-> o_flash_opt_sel)
		else $error("program under readout protection");
endmodule : flash_prot_asserts
bind flash_program_mode_protection flash_prot_asserts #(.FLASH_AW(FLASH_AW)) u_chk (
	.i_mclk, .i_rst_n, .i_tool_socket_mode, .i_option_byte, .o_flash_addr,
	.o_flash_wdata, .o_flash_prog, .o_flash_erase, .o_flash_opt_sel,
	.o_fetch_system_vector, .o_ext_clock_select, .o_force_internal_rc,
	.o_readout_block, .o_incircuit_clock_pin_oe
);

/* bench/incircuit_tool.sv */
// tool model: owns reset and sends the entry pulse train
`timescale 1ns/1ps
module incircuit_tool (
	input wire logic i_mclk,
	input wire logic i_go,
	input wire logic [5:0] i_pulses,
	output logic o_rst_n = 1'b1,
	output logic o_clk = 1'b1,
	output logic o_data = 1'b0,
	output logic o_done = 1'b0
);
	// tool holds reset around the pulse train
	always @(posedge i_go) begin
		o_done = 1'b0;
		@(posedge i_mclk) o_rst_n <= 1'b0;
		repeat (5) @(posedge i_mclk);
		#1.3;
		// a lead-in edge with data low clears a count left from an earlier session
		#3 o_clk = 1'b0;
		#3 o_clk = 1'b1;
		repeat (i_pulses) begin
			#3 o_clk = 1'b0;
			o_data = 1'b1;
			#3 o_clk = 1'b1;
		end
		// released data line shows the inverse of its last level
		#3 o_data = 1'b0;
		// the entry flag needs its three-flop crossing done before release
		repeat (5) @(posedge i_mclk);
		o_rst_n <= 1'b1;
		o_done = 1'b1;
	end
endmodule : incircuit_tool

/* bench/tb.sv */
// self-checking bench for the flash programming and protection controller
`timescale 1ns/1ps
module tb;
	import flash_prot_pkg::*;
	logic mclk = 1'b0, rst_n = 1'b0, socket = 1'b0, wstb = 1'b0, rstb = 1'b0;
	logic busy = 1'b0, go = 1'b0;
	logic [7:0] opt = 8'h00, addr = 8'h00, wdata = 8'h00, rdata, fwdata;
	logic [5:0] npulse = 6'h00;
	logic [12:0] faddr;
	logic prog, erase, osel, sect, fetch, extc, frc, roblk, pout, poe;
	logic trst_n, tclk, tdata, tdone;
	logic [23:0] log_q[$];
	int mismatches = 0, checked = 0, bcnt = 0;
	// pin is pulled up when idle; the tool clock idles high too
	wire pin = poe ? pout : tclk;
	flash_program_mode_protection uut (
		.i_mclk(mclk), .i_rst_n(rst_n & trst_n), .i_incircuit_clock_pin(pin),
		.i_incircuit_data_pin(tdata), .i_tool_socket_mode(socket), .i_option_byte(opt),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wstb), .i_rd(rstb), .o_rdata(rdata),
		.o_flash_addr(faddr), .o_flash_wdata(fwdata), .o_flash_prog(prog),
		.o_flash_erase(erase), .o_flash_opt_sel(osel), .o_flash_sector(sect),
		.i_flash_busy(busy), .o_fetch_system_vector(fetch), .o_ext_clock_select(extc),
		.o_force_internal_rc(frc), .o_readout_block(roblk),
		.o_incircuit_clock_pin_out(pout), .o_incircuit_clock_pin_oe(poe)
	);
	incircuit_tool u_tool (
		.i_mclk(mclk), .i_go(go), .i_pulses(npulse), .o_rst_n(trst_n),
		.o_clk(tclk), .o_data(tdata), .o_done(tdone)
	);
	initial forever #50 mclk = ~mclk;
	// flash macro stand-in: busy a few cycles after each pulse
	always @(posedge mclk) begin
		if (prog | erase)
			log_q.push_back({erase, osel, sect, faddr, fwdata});
		busy <= prog | erase | (bcnt > 1);
		bcnt <= (prog | erase) ? 3 : (bcnt > 0 ? bcnt - 1 : 0);
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string n, input logic [23:0] g, input logic [23:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wstb <= 1'b1;
		@(posedge mclk);
		wstb <= 1'b0;
		@(posedge mclk);
	endtask : wreg
	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rstb <= 1'b1;
		@(posedge mclk);
		rstb <= 1'b0;
		@(negedge mclk);
		d = rdata;
		@(posedge mclk);
	endtask : rreg
	task automatic stat(input logic [7:0] m, input logic [7:0] e);
		logic [7:0] s;
		rreg(REG_STATUS, s);
		chk("status", s & m, e);
	endtask : stat
	task automatic idle;
		logic [7:0] s;
		int i;
		s = 8'h01;
		for (i = 0; i < 100 && s[STAT_BUSY] !== 1'b0; i++)
			rreg(REG_STATUS, s);
		if (i == 100) begin
			chk("busy", 1'b1, 1'b0);
			wrap_up();
		end
	endtask : idle
	task automatic op(input logic [15:0] a, input logic [7:0] c);
		wreg(REG_ADDR_LO, a[7:0]);
		wreg(REG_ADDR_HI, a[15:8]);
		wreg(REG_DATA, 8'h5a);
		wreg(REG_CTRL, c);
		idle();
	endtask : op
	task automatic boot(input logic [7:0] o, input logic s);
		opt <= o;
		socket <= s;
		rst_n <= 1'b0;
		// four edges in reset let the pin synchronizer settle
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		log_q.delete();
	endtask : boot
	task automatic t_reset;
		logic [7:0] d;
		boot(8'h00, 1'b0);
		wreg(REG_CTRL, 8'h08);
		rreg(REG_CTRL, d);
		chk("ctrl", d & 8'h18, 8'h08);
		chk("pin", pin, 1'b0);
		opt <= 8'h03;
		stat(8'h60, 8'h00);
		boot(8'h00, 1'b0);
		chk("pin oe", poe, 1'b0);
		chk("pin", pin, 1'b1);
		$display("reset test done");
	endtask : t_reset
	task automatic t_iap;
		boot(8'h14, 1'b0);
		chk("ext clock", extc, 1'b1);
		op(16'h0200, 8'h01);
		stat(8'hff, 8'h80);
		wreg(REG_CTRL, 8'h80);
		wreg(REG_CTRL, 8'h05);
		stat(8'hff, 8'h80);
		wreg(REG_CTRL, 8'h80);
		wreg(REG_ADDR_LO, 8'h00);
		wreg(REG_ADDR_HI, 8'h04);
		wreg(REG_DATA, 8'h11);
		wreg(REG_ADDR_LO, 8'h05);
		wreg(REG_DATA, 8'h22);
		wreg(REG_CTRL, 8'h01);
		idle();
		chk("pulses", log_q.size(), 2);
		chk("row 0", log_q[0] & 24'hdfffff, 24'h040011);
		chk("row 5", log_q[1] & 24'hdfffff, 24'h040522);
		op(16'h0400, 8'h02);
		chk("erase 1", log_q[2] & 24'hffff00, 24'ha40000);
		$display("iap test done");
	endtask : t_iap
	task automatic t_prot;
		boot(8'h02, 1'b1);
		stat(8'h60, 8'h40);
		op(16'h0200, 8'h01);
		op(16'h0000, 8'h06);
		stat(8'he0, 8'hc0);
		chk("pulses", log_q.size(), 0);
		boot(8'h01, 1'b1);
		stat(8'h60, 8'h20);
		chk("ro block", roblk, 1'b1);
		op(16'h0200, 8'h01);
		stat(8'h80, 8'h80);
		wreg(REG_CTRL, 8'h80);
		op(16'h0000, 8'h06);
		chk("pulses", log_q.size(), 3);
		chk("erase 0", log_q[0] & 24'he00000, 24'h800000);
		chk("erase 1", log_q[1] & 24'he00000, 24'ha00000);
		chk("erase opt", log_q[2] & 24'hc00000, 24'hc00000);
		$display("protection test done");
	endtask : t_prot
	task automatic t_entry(input logic [5:0] n);
		int i;
		boot(8'h00, 1'b0);
		npulse <= n;
		go <= 1'b1;
		@(posedge mclk);
		for (i = 0; i < 50 && tdone !== 1'b1; i++)
			@(posedge mclk);
		if (i == 50) begin
			chk("tool", 1'b0, 1'b1);
			wrap_up();
		end
		go <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("vector", fetch, 1'b1);
		chk("ext clock", extc, n == 6'h23);
		chk("rc forced", frc, n == 6'h26);
		stat(8'h1c, {3'h0, n == 6'h26, n == 6'h23, 3'h4});
		op(16'h0000, 8'h01);
		chk("sector0", log_q[0] & 24'hdfffff, 24'h00005a);
		$display("entry test done");
	endtask : t_entry
	initial begin
		@(posedge mclk);
		t_reset();
		t_iap();
		t_prot();
		t_entry(6'h23);
		t_entry(6'h26);
		wrap_up();
	end
endmodule : tb
